/* src/sbte_pkg.sv */
package sbte_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_STATUS     = 8'h04;
    localparam logic [7:0] ADDR_DATA       = 8'h08;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_INT_MASK   = 8'h10;

    // control field positions
    localparam int CTRL_ENABLE_BIT    = 0;
    localparam int CTRL_MASTER_BIT    = 1;
    localparam int CTRL_LSB_FIRST_BIT = 2;
    localparam int CTRL_CPHA_BIT      = 3;
    localparam int CTRL_CPOL_BIT      = 4;
    localparam int CTRL_PRESCALE_LSB  = 8;
    localparam int CTRL_RATE_LSB      = 12;
    localparam int SEL_W              = 3;

    // status and interrupt field positions
    localparam int STAT_TXE_BIT  = 0;
    localparam int STAT_RXF_BIT  = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int INT_W         = 2;
    localparam int INT_TXE_BIT   = 0;
    localparam int INT_RXF_BIT   = 1;

    // transfer framing: eight bits, two shift-clock edges each
    localparam int               BITS_PER_XFER = 8;
    localparam int               HALF_W        = 4;
    localparam logic [HALF_W-1:0] LAST_HALF    = 4'hF;
    localparam int               DIV_W         = 11;
    localparam int               SYNC_W        = 4;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
endpackage

/* src/sbte_pin_sync.sv */
`timescale 1ns/1ps
module sbte_pin_sync
    import sbte_pkg::*;
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // raw pins and filtered levels
    input  wire logic [SYNC_W-1:0] raw,
    output logic      [SYNC_W-1:0] filt
);
    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] f;
    } sbte_sync_s;

    sbte_sync_s s_q;
    sbte_sync_s s_d;

    // a level is taken only once the second and third stages agree
    always_comb begin
        s_d    = s_q;
        s_d.s1 = raw;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        for (int i = 0; i < SYNC_W; i++) begin
            if (s_q.s2[i] == s_q.s3[i]) begin
                s_d.f[i] = s_q.s3[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign filt = s_q.f;
endmodule

/* src/sbte_rate_div.sv */
`timescale 1ns/1ps
module sbte_rate_div
    import sbte_pkg::*;
(
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // divider control
    input  wire logic             run,
    input  wire logic [SEL_W-1:0] prescale_select,
    input  wire logic [SEL_W-1:0] rate_select,
    // one pulse per half bit period
    output logic                  tick
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
    } sbte_div_s;

    sbte_div_s        s_q;
    sbte_div_s        s_d;
    logic [DIV_W-1:0] half;

    // bit period = (prescale+1) * 2^(rate+1) bus clocks, so half of it here
    assign half = DIV_W'({ {(DIV_W-SEL_W){1'b0}}, prescale_select } + DIV_W'(1)) << rate_select;
    assign tick = run && (s_q.cnt == half - DIV_W'(1));

    always_comb begin
        s_d = s_q;
        if (!run || tick) begin
            s_d.cnt = '0;
        end else begin
            s_d.cnt = s_q.cnt + DIV_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    AST_DIV_SPACING: assert property (@(posedge pclk) disable iff (!presetn)
        run && tick && prescale_select == 3'h1 && rate_select == 3'h0 && $stable(prescale_select) ##1 run
        |-> !tick ##1 (tick || !run)) else $error("half period of two clocks not kept");
endmodule

/* src/sbte_top.sv */
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module sbte_top
    import sbte_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // interrupt
    output logic             irq,
    // shift clock pin
    input  wire logic        shift_clock_pin_i,
    output logic             shift_clock_pin_o,
    output logic             shift_clock_pin_oe,
    // master-out data pin
    input  wire logic        serial_out_pin_i,
    output logic             serial_out_pin_o,
    output logic             serial_out_pin_oe,
    // master-in data pin
    input  wire logic        serial_in_pin_i,
    output logic             serial_in_pin_o,
    output logic             serial_in_pin_oe,
    // target select, active low
    input  wire logic        target_select_n_i,
    output logic             target_select_n_o,
    output logic             target_select_n_oe
);
    typedef struct packed {
        logic              enable;
        logic              master;
        logic              lsb_first_enable;
        logic              cpha;
        logic              cpol;
        logic [SEL_W-1:0]  prescale_select;
        logic [SEL_W-1:0]  rate_select;
        logic [7:0]        tx_buf;
        logic              tx_buffer_empty_flag;
        logic [7:0]        rx_buf;
        logic              rx_buffer_full_flag;
        logic              rx_armed;
        logic              busy;
        logic [7:0]        shifter;
        logic              samp;
        logic [HALF_W-1:0] half_cnt;
        logic              sck;
        logic              sck_prev;
        logic [INT_W-1:0]  int_status;
        logic [INT_W-1:0]  int_mask;
        logic [31:0]       rdata;
        logic              ready;
        logic              slverr;
    } sbte_state_s;

    sbte_state_s       s_q;
    sbte_state_s       s_d;
    logic [SYNC_W-1:0] pin_f;
    logic              tick;
    logic              sck_f;
    logic              mosi_f;
    logic              miso_f;
    logic              ss_n_f;
    logic              setup;
    logic              access;
    logic              wr_data;
    logic              rd_data;
    logic              rd_status;
    logic              rd_int;
    logic              rx_clr;
    logic              edge_ev;
    logic              in_bit;
    logic              lead;
    logic              done;
    logic [7:0]        done_byte;
    logic              start;
    logic              out_bit;

    // every pin input is resynchronised; in master mode this adds four bus
    // clocks of lag to the sampled data, so very fast rates need a short line
    sbte_pin_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .raw     ({target_select_n_i, serial_in_pin_i, serial_out_pin_i, shift_clock_pin_i}),
        .filt    (pin_f)
    );
    assign sck_f  = pin_f[0];
    assign mosi_f = pin_f[1];
    assign miso_f = pin_f[2];
    assign ss_n_f = pin_f[3];

    sbte_rate_div u_div (
        .pclk            (pclk),
        .presetn         (presetn),
        .run             (s_q.busy && s_q.master && s_q.enable),
        .prescale_select (s_q.prescale_select),
        .rate_select     (s_q.rate_select),
        .tick            (tick)
    );

    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b, input logic lsb);
        shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction

    // apb decode
    assign setup     = psel && !penable;
    assign access    = psel && penable && s_q.ready;
    assign wr_data   = access && pwrite && paddr == ADDR_DATA;
    assign rd_data   = access && !pwrite && paddr == ADDR_DATA;
    assign rd_status = access && !pwrite && paddr == ADDR_STATUS;
    assign rd_int    = access && !pwrite && paddr == ADDR_INT_STATUS;
    assign rx_clr    = rd_data && s_q.rx_armed;

    // one shift-clock edge: own divider as master, filtered pin edge as slave
    assign edge_ev = s_q.enable && (s_q.master ? (s_q.busy && tick)
                                               : (!ss_n_f && sck_f != s_q.sck_prev));
    assign in_bit  = s_q.master ? miso_f : mosi_f;
    assign lead    = !s_q.half_cnt[0];
    assign done    = edge_ev && s_q.half_cnt == LAST_HALF;
    assign done_byte = shift_in(s_q.shifter, s_q.cpha ? in_bit : s_q.samp, s_q.lsb_first_enable);
    // a queued byte may enter an idle shifter; slaves wait for a clean frame
    assign start   = s_q.enable && !s_q.busy && !s_q.tx_buffer_empty_flag
                     && (s_q.master || s_q.half_cnt == '0);

    always_comb begin
        s_d        = s_q;
        s_d.ready  = 1'b0;
        s_d.sck_prev = sck_f;

        // apb setup phase prepares the answer so the access phase needs no wait
        if (setup) begin
            s_d.ready  = 1'b1;
            s_d.slverr = 1'b0;
            s_d.rdata  = ZERO_WORD;
            if (paddr == ADDR_CTRL) begin
                s_d.rdata[CTRL_ENABLE_BIT]    = s_q.enable;
                s_d.rdata[CTRL_MASTER_BIT]    = s_q.master;
                s_d.rdata[CTRL_LSB_FIRST_BIT] = s_q.lsb_first_enable;
                s_d.rdata[CTRL_CPHA_BIT]      = s_q.cpha;
                s_d.rdata[CTRL_CPOL_BIT]      = s_q.cpol;
                s_d.rdata[CTRL_PRESCALE_LSB +: SEL_W] = s_q.prescale_select;
                s_d.rdata[CTRL_RATE_LSB +: SEL_W]     = s_q.rate_select;
            end else if (paddr == ADDR_STATUS) begin
                s_d.rdata[STAT_TXE_BIT]  = s_q.tx_buffer_empty_flag;
                s_d.rdata[STAT_RXF_BIT]  = s_q.rx_buffer_full_flag;
                s_d.rdata[STAT_BUSY_BIT] = s_q.busy;
            end else if (paddr == ADDR_DATA) begin
                s_d.rdata[7:0] = s_q.rx_buf;
            end else if (paddr == ADDR_INT_STATUS) begin
                s_d.rdata[INT_W-1:0] = s_q.int_status;
            end else if (paddr == ADDR_INT_MASK) begin
                s_d.rdata[INT_W-1:0] = s_q.int_mask;
            end else begin
                s_d.slverr = 1'b1;
            end
        end

        // register writes
        if (access && pwrite) begin
            if (paddr == ADDR_CTRL) begin
                s_d.enable           = pwdata[CTRL_ENABLE_BIT];
                s_d.master           = pwdata[CTRL_MASTER_BIT];
                s_d.lsb_first_enable = pwdata[CTRL_LSB_FIRST_BIT];
                s_d.cpha             = pwdata[CTRL_CPHA_BIT];
                s_d.cpol             = pwdata[CTRL_CPOL_BIT];
                s_d.prescale_select  = pwdata[CTRL_PRESCALE_LSB +: SEL_W];
                s_d.rate_select      = pwdata[CTRL_RATE_LSB +: SEL_W];
            end else if (paddr == ADDR_DATA) begin
                // a write to a full buffer overwrites the queued byte
                s_d.tx_buf               = pwdata[7:0];
                s_d.tx_buffer_empty_flag = 1'b0;
            end else if (paddr == ADDR_INT_MASK) begin
                s_d.int_mask = pwdata[INT_W-1:0];
            end
        end

        // rx full clears only on a data read after the flag was seen set
        if (rd_status && s_q.rx_buffer_full_flag) begin
            s_d.rx_armed = 1'b1;
        end
        if (rd_data) begin
            s_d.rx_armed = 1'b0;
        end
        if (rx_clr) begin
            s_d.rx_buffer_full_flag = 1'b0;
        end
        if (rd_int) begin
            s_d.int_status = '0;
        end

        // slave frame abort: select released resets bit position
        if (!s_q.master && ss_n_f) begin
            s_d.half_cnt = '0;
        end

        if (edge_ev) begin
            s_d.half_cnt = s_q.half_cnt + HALF_W'(1);
            if (s_q.master) begin
                s_d.sck = !s_q.sck;
            end
            if (done) begin
                s_d.shifter = done_byte;
            end else if (lead != s_q.cpha) begin
                s_d.samp = in_bit;
            end else if (!(s_q.cpha && s_q.half_cnt == '0)) begin
                s_d.shifter = shift_in(s_q.shifter, s_q.samp, s_q.lsb_first_enable);
            end
        end

        if (done) begin
            // double buffer: the old byte stays until software takes it
            if (!s_q.rx_buffer_full_flag || rx_clr) begin
                s_d.rx_buf              = done_byte;
                s_d.rx_buffer_full_flag = 1'b1;
                s_d.int_status[INT_RXF_BIT] = 1'b1;
            end
            if (!s_q.tx_buffer_empty_flag) begin
                s_d.shifter              = s_q.tx_buf;
                s_d.tx_buffer_empty_flag = 1'b1;
                s_d.int_status[INT_TXE_BIT] = 1'b1;
            end else begin
                s_d.busy = 1'b0;
            end
        end else if (start) begin
            s_d.shifter              = s_q.tx_buf;
            s_d.tx_buffer_empty_flag = 1'b1;
            s_d.int_status[INT_TXE_BIT] = 1'b1;
            s_d.busy                 = 1'b1;
            s_d.half_cnt             = '0;
            s_d.sck                  = s_q.cpol;
        end

        if (!s_q.enable) begin
            s_d.busy     = 1'b0;
            s_d.half_cnt = '0;
            s_d.sck      = s_q.cpol;
        end
        if (!s_q.busy && s_q.master) begin
            s_d.sck = s_q.cpol;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q                      <= '0;
            s_q.tx_buffer_empty_flag <= 1'b1;
            s_q.enable               <= CTRL_RESET[CTRL_ENABLE_BIT];
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    assign out_bit            = s_q.lsb_first_enable ? s_q.shifter[0] : s_q.shifter[7];
    assign prdata             = s_q.rdata;
    assign pready             = s_q.ready;
    assign pslverr            = s_q.slverr;
    assign irq                = |(s_q.int_status & s_q.int_mask);
    assign shift_clock_pin_o  = s_q.sck;
    assign shift_clock_pin_oe = s_q.enable && s_q.master;
    assign serial_out_pin_o   = out_bit;
    assign serial_out_pin_oe  = s_q.enable && s_q.master;
    assign serial_in_pin_o    = out_bit;
    assign serial_in_pin_oe   = s_q.enable && !s_q.master && !ss_n_f;
    assign target_select_n_o  = !s_q.busy;
    assign target_select_n_oe = s_q.enable && s_q.master;

    AST_START_LOADS: assert property (@(posedge pclk) disable iff (!presetn)
        start && !done |=> s_q.busy && s_q.tx_buffer_empty_flag && s_q.shifter == $past(s_q.tx_buf))
        else $error("queued byte did not enter the shifter");
    AST_FIRST_BIT: assert property (@(posedge pclk) disable iff (!presetn)
        start && !done && !s_q.lsb_first_enable && !(access && pwrite)
        |=> serial_out_pin_o == $past(s_q.tx_buf[7])) else $error("first bit is not the msb");
    AST_FIRST_BIT_LSB: assert property (@(posedge pclk) disable iff (!presetn)
        start && !done && s_q.lsb_first_enable && !(access && pwrite)
        |=> serial_out_pin_o == $past(s_q.tx_buf[0])) else $error("first bit is not the lsb");
    AST_SCK_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.master && edge_ev && !done |=> shift_clock_pin_o != $past(shift_clock_pin_o))
        else $error("shift clock did not toggle on a half period");
    AST_RX_STORE: assert property (@(posedge pclk) disable iff (!presetn)
        done && !s_q.rx_buffer_full_flag |=> s_q.rx_buffer_full_flag && s_q.rx_buf == $past(done_byte))
        else $error("received byte not buffered");
    AST_OVERRUN: assert property (@(posedge pclk) disable iff (!presetn)
        done && s_q.rx_buffer_full_flag && !rx_clr |=> s_q.rx_buf == $past(s_q.rx_buf) && s_q.rx_buffer_full_flag)
        else $error("overrun replaced the buffered byte");
    AST_BACK_TO_BACK: assert property (@(posedge pclk) disable iff (!presetn)
        done && !s_q.tx_buffer_empty_flag && s_q.enable |=> s_q.busy && s_q.tx_buffer_empty_flag && s_q.half_cnt == '0)
        else $error("queued byte did not start the next transfer");
    AST_FRAME_END: assert property (@(posedge pclk) disable iff (!presetn)
        done |-> s_q.half_cnt == LAST_HALF ##1 s_q.half_cnt == '0) else $error("transfer not sixteen edges");
    AST_TXE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        wr_data && !start && !done |=> !s_q.tx_buffer_empty_flag) else $error("data write left tx empty set");
    AST_RXF_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        rx_clr && !done |=> !s_q.rx_buffer_full_flag) else $error("armed data read left rx full set");
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        rd_int && !done && !start |=> !irq) else $error("interrupt survived a status read");
endmodule

/* sim/sbte_slave_model.sv */
`timescale 1ns/1ps
module sbte_slave_model (
    // serial pins
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    output logic            miso,
    // bench side
    input  wire logic [7:0] tx_byte,
    output logic      [7:0] rx_byte,
    output logic      [7:0] n_rx
);
    logic [7:0] sh_tx = 8'h00;
    logic [7:0] sh_rx = 8'h00;
    logic [3:0] cnt   = 4'h0;
    initial begin
        rx_byte = 8'h00;
        n_rx = 8'h00;
    end
    // a deselected target shows the inverse level, never a stale bit
    assign miso = sel_n ? ~sh_tx[7] : sh_tx[7];
    always @(negedge sel_n) begin
        sh_tx = tx_byte + n_rx;
        cnt = 4'h0;
    end
    always @(posedge sck) begin
        if (!sel_n) begin
            sh_rx = {sh_rx[6:0], mosi};
            cnt = cnt + 4'h1;
            if (cnt == 4'h8) begin
                rx_byte = sh_rx;
                n_rx = n_rx + 8'h01;
            end
        end
    end
    // select may stay low across transfers, so reload on the bit count
    always @(negedge sck) begin
        if (!sel_n && cnt == 4'h8) begin
            sh_tx = tx_byte + n_rx;
            cnt = 4'h0;
        end else if (!sel_n) begin
            sh_tx = {sh_tx[6:0], 1'b0};
        end
    end
endmodule

/* sim/test_sbte_top.sv */
`timescale 1ns/1ps
module test_sbte_top;
    import sbte_pkg::*;
    logic pclk, presetn, psel, penable, pwrite;
    logic [7:0] paddr, rx_m, nrx_m;
    logic [7:0] tx_m = 8'h3C;
    logic [31:0] pwdata, prdata, rdat;
    logic pready, pslverr, irq, err, miso_m;
    logic sck_o, sck_oe, mo_o, mo_oe, mi_o, mi_oe, ss_o, ss_oe;
    int n_fail = 0;
    int comparisons = 0;
    wire sck_w = sck_oe ? sck_o : 1'b0;
    wire mo_w  = mo_oe ? mo_o : 1'b0;
    wire mi_w  = mi_oe ? mi_o : miso_m;
    wire ss_w  = ss_oe ? ss_o : 1'b1;
    sbte_top i_sbte_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .shift_clock_pin_i(sck_w), .shift_clock_pin_o(sck_o), .shift_clock_pin_oe(sck_oe),
        .serial_out_pin_i(mo_w), .serial_out_pin_o(mo_o), .serial_out_pin_oe(mo_oe),
        .serial_in_pin_i(mi_w), .serial_in_pin_o(mi_o), .serial_in_pin_oe(mi_oe),
        .target_select_n_i(ss_w), .target_select_n_o(ss_o), .target_select_n_oe(ss_oe));
    sbte_slave_model i_sbte_slave_model (.sck(sck_w), .mosi(mo_w), .sel_n(ss_w), .miso(miso_m),
        .tx_byte(tx_m), .rx_byte(rx_m), .n_rx(nrx_m));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // look at pready while it is settled, then let the edge that takes it pass
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(1'b0, 1'b1, "pready timeout");
        rdat = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp, input string w);
        apb(1'b0, a, ZERO_WORD);
        chk(rdat & msk, exp, w);
    endtask
    function automatic logic [7:0] rev8(input logic [7:0] x);
        rev8 = {<<{x}};
    endfunction
    function automatic logic [31:0] ctrl(input int p, input int r, input logic lsb);
        ctrl = 32'h0000_0003 | (32'(lsb) << CTRL_LSB_FIRST_BIT) | (32'(p) << CTRL_PRESCALE_LSB) | (32'(r) << CTRL_RATE_LSB);
    endfunction
    task automatic t_reset();
        rd_chk(ADDR_CTRL, 32'hFFFF_FFFF, CTRL_RESET, "ctrl reset");
        rd_chk(ADDR_STATUS, 32'hFFFF_FFFF, 32'h0000_0001, "status reset");
        apb(1'b0, 8'h20, ZERO_WORD);
        chk({31'h0, err}, 32'h1, "unmapped err");
        chk(rdat, ZERO_WORD, "unmapped data");
        $display("test reset done");
    endtask
    task automatic t_xfer(input int p, input int r, input logic lsb, input logic [7:0] d);
        int h, cyc, tg;
        logic last;
        logic [7:0] m;
        h = (p + 1) << r;
        apb(1'b1, ADDR_CTRL, ctrl(p, r, lsb));
        rd_chk(ADDR_STATUS, 32'h0000_0001, 32'h0000_0001, "tx empty before write");
        m = tx_m + nrx_m;
        apb(1'b1, ADDR_DATA, {24'h0, d});
        last = sck_w;
        cyc = 0;
        tg = 0;
        while (tg < 16 && cyc < 20000) begin
            @(negedge pclk);
            if (tg > 0) cyc++;
            if (sck_w !== last) tg++;
            last = sck_w;
        end
        chk(cyc, 15 * h, "half period");
        cyc = 0;
        do begin
            apb(1'b0, ADDR_STATUS, ZERO_WORD);
            cyc++;
        end while (rdat[STAT_RXF_BIT] !== 1'b1 && cyc < 3000);
        chk(rx_m, lsb ? rev8(d) : d, "target got");
        rd_chk(ADDR_DATA, 32'h0000_00FF, {24'h0, lsb ? rev8(m) : m}, "rx byte");
        rd_chk(ADDR_STATUS, 32'h0000_0007, 32'h0000_0001, "rx full cleared");
        $display("test transfer %0d %0d %0d done", p, r, lsb);
    endtask
    task automatic t_b2b();
        int n;
        logic [7:0] n0;
        // half period of five: the input synchroniser needs four bus clocks
        apb(1'b1, ADDR_CTRL, ctrl(4, 0, 1'b0));
        apb(1'b1, ADDR_INT_MASK, 32'h0000_0002);
        apb(1'b0, ADDR_INT_STATUS, ZERO_WORD);
        @(posedge pclk);
        chk(irq, 1'b0, "irq after clear");
        n0 = nrx_m;
        apb(1'b1, ADDR_DATA, 32'h0000_0011);
        rd_chk(ADDR_STATUS, 32'h0000_0005, 32'h0000_0005, "tx empty once shifting");
        apb(1'b1, ADDR_DATA, 32'h0000_0022);
        rd_chk(ADDR_STATUS, 32'h0000_0001, ZERO_WORD, "tx empty cleared by write");
        n = 0;
        while (nrx_m !== n0 + 8'h02 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        chk(n < 1000, 1'b1, "second transfer started");
        repeat (8) @(posedge pclk);
        chk(rx_m, 8'h22, "target got second");
        chk(irq, 1'b1, "irq unmasked rx full");
        rd_chk(ADDR_STATUS, 32'h0000_0007, 32'h0000_0003, "idle and full");
        rd_chk(ADDR_DATA, 32'h0000_00FF, {24'h0, tx_m + n0}, "overrun keeps first");
        rd_chk(ADDR_INT_STATUS, 32'h0000_0002, 32'h0000_0002, "rx event");
        @(posedge pclk);
        chk(irq, 1'b0, "irq cleared by read");
        $display("test back to back done");
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 8'h00;
        pwdata = ZERO_WORD;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_xfer(4, 0, 1'b0, 8'hA5);
        t_xfer(1, 2, 1'b1, 8'h01);
        t_xfer(0, 7, 1'b0, 8'hC3);
        t_xfer(7, 0, 1'b1, 8'h5E);
        t_b2b();
        close_out();
    end
    initial begin
        repeat (60000) @(posedge pclk);
        chk(1'b0, 1'b1, "watchdog");
        close_out();
    end
endmodule
